// file: src/kpd_pkg.sv
// kpd_pkg: register map, field layout, reset values and timing for the keypad scanner
package kpd_pkg;
  // clock and keypad timebase
  localparam int unsigned CLK_FREQ_HZ = 125_000_000;
  localparam int unsigned KEYPAD_CLOCK_LEVEL_FREQ_HZ = 1000;
  localparam int unsigned KEYPAD_CLOCK_LEVEL_HALF_CYCLES = CLK_FREQ_HZ / (2 * KEYPAD_CLOCK_LEVEL_FREQ_HZ);
  localparam int unsigned DIV_W = 17;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_COLUMN_RESULT = 8'hd1;
  localparam logic [7:0] IDX_ROW_RESULT = 8'hd2;
  localparam logic [7:0] IDX_SCAN_TIMING = 8'hd3;
  localparam logic [7:0] IDX_CONTROL_STATUS = 8'hd4;
  localparam logic [7:0] IDX_CLOCK_CONTROL = 8'hd8;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hd9;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hda;

  // reset values
  localparam logic [4:0] RST_COLUMN_RESULT = 5'h1f;
  localparam logic [5:0] RST_ROW_RESULT = 6'h3f;
  localparam logic [7:0] RST_SCAN_TIMING = 8'h00;
  localparam logic [1:0] RST_IRQ_MASK = 2'h3;

  // scan timing fields
  localparam int unsigned SCT_LSB = 0;
  localparam int unsigned DBT_LSB = 2;
  localparam int unsigned DB_STEP_MS = 4;
  localparam logic [6:0] DB_ZERO_STEPS = 7'h40;
  localparam logic [8:0] SCAN_MS_CODE0 = 9'h004;
  localparam logic [8:0] SCAN_MS_CODE3 = 9'h003;

  // control/status bit positions
  localparam int unsigned CS_IRQ_EN = 0;
  localparam int unsigned CS_KEY_DET = 1;
  localparam int unsigned CS_HW_EN = 2;
  localparam int unsigned CS_KCLK = 3;

  // interrupt status / mask bit positions
  localparam int unsigned IRQ_KEY_DET = 0;
  localparam int unsigned IRQ_KEY_REL = 1;

  localparam int unsigned NUM_COLS = 5;
  localparam int unsigned NUM_ROWS = 6;

  typedef enum logic [2:0] {
    SC_IDLE,
    SC_DEB_PRESS,
    SC_SCAN,
    SC_WAIT_REL,
    SC_DEB_REL
  } kpd_scan_e;

  typedef struct packed {
    logic ahb_wr;
    logic [7:0] ahb_idx;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [DIV_W-1:0] div_cnt;
    logic keypad_clock_level;
    logic keypad_clock_gate;
    logic [7:0] scan_timing;
    logic hardware_scan_enable;
    logic key_detect_irq_enable;
    logic key_detect_flag;
    logic key_release_flag;
    logic [1:0] irq_mask;
    logic [4:0] column_result;
    logic [5:0] row_result;
    kpd_scan_e scan_state;
    logic [8:0] tcnt;
    logic [2:0] col_idx;
    logic [1:0] hits;
    logic [4:0] hit_col;
    logic [5:0] hit_row;
    logic rows_all_high;
    logic [4:0] col_drive;
    logic irq;
  } kpd_state_s;
endpackage

// file: src/kpd_scan_ctrl.sv
// kpd_scan_ctrl: keypad scan, debounce and key-detect control with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none

module kpd_scan_ctrl #(
  parameter int unsigned KCLK_HALF = kpd_pkg::KEYPAD_CLOCK_LEVEL_HALF_CYCLES
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // keypad pins
  output logic [kpd_pkg::NUM_COLS-1:0] col_o,
  input wire logic [kpd_pkg::NUM_ROWS-1:0] row_i,
  // interrupt
  output logic irq_o
);

  logic [1:0] rst_sync_r;
  logic rst_n;
  kpd_pkg::kpd_state_s s_r;
  kpd_pkg::kpd_state_s s_nxt;

  // reset enters at once but leaves on the clock, so no state flop sees its release
  // land right at a sampling edge
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // debounce length in ms, code zero stretches to the full 256 ms
  function automatic logic [8:0] db_ms(input logic [5:0] code);
    logic [6:0] steps;
    steps = (code == 6'h00) ? kpd_pkg::DB_ZERO_STEPS : {1'b0, code};
    return {steps, 2'b00};
  endfunction

  // per-column dwell in ms; code zero takes the longest dwell, like the debounce field
  function automatic logic [8:0] scan_ms(input logic [1:0] code);
    logic [8:0] ms;
    case (code)
      2'h1: begin
        ms = 9'h001;
      end
      2'h2: begin
        ms = 9'h002;
      end
      2'h3: begin
        ms = kpd_pkg::SCAN_MS_CODE3;
      end
      default: begin
        ms = kpd_pkg::SCAN_MS_CODE0;
      end
    endcase
    return ms;
  endfunction

  always_comb begin
    logic ms_tick;
    logic addr_ok;
    logic rd_cs;
    logic rd_irq;
    logic any_low;
    logic all_high;
    logic set_kd;
    logic set_rel;
    logic [2:0] nlow;
    logic [5:0] rlow;
    logic [31:0] rdat;
    logic [7:0] aidx;
    logic [8:0] db_len;
    logic irq_det;
    logic irq_rel;
    ms_tick = 1'b0;
    irq_det = 1'b0;
    irq_rel = 1'b0;
    addr_ok = 1'b0;
    rd_cs = 1'b0;
    rd_irq = 1'b0;
    set_kd = 1'b0;
    set_rel = 1'b0;
    nlow = 3'h0;
    rdat = 32'h0;
    s_nxt = s_r;
    rlow = ~row_i;
    any_low = |rlow;
    all_high = &row_i;
    aidx = haddr_i[9:2];
    db_len = db_ms(s_r.scan_timing[7:kpd_pkg::DBT_LSB]);
    for (int i = 0; i < kpd_pkg::NUM_ROWS; i++) begin
      nlow = nlow + {2'h0, rlow[i]};
    end

    // keypad timebase; gating the clock freezes scanning and debouncing
    if (s_r.keypad_clock_gate) begin
      if (s_r.div_cnt >= KCLK_HALF[kpd_pkg::DIV_W-1:0] - 1'b1) begin
        s_nxt.div_cnt = '0;
        s_nxt.keypad_clock_level = ~s_r.keypad_clock_level;
        ms_tick = ~s_r.keypad_clock_level;
      end else begin
        s_nxt.div_cnt = s_r.div_cnt + 1'b1;
      end
    end

    // ahb-lite address phase
    s_nxt.ahb_wr = 1'b0;
    s_nxt.hreadyout = 1'b1;
    if (hsel_i && htrans_i[1] && hready_i) begin
      addr_ok = (haddr_i[31:10] == 22'h0) && (haddr_i[1:0] == 2'h0);
      s_nxt.ahb_idx = aidx;
      // writes outside the map are dropped here, so no aliased index can be hit
      s_nxt.ahb_wr = hwrite_i && addr_ok;
      if (!hwrite_i && addr_ok) begin
        case (aidx)
          kpd_pkg::IDX_COLUMN_RESULT: begin
            rdat = {27'h0, s_r.column_result};
          end
          kpd_pkg::IDX_ROW_RESULT: begin
            // in bypass the row register shows the live sense lines
            rdat = {26'h0, s_r.hardware_scan_enable ? s_r.row_result : row_i};
          end
          kpd_pkg::IDX_SCAN_TIMING: begin
            rdat = {24'h0, s_r.scan_timing};
          end
          kpd_pkg::IDX_CONTROL_STATUS: begin
            rdat[kpd_pkg::CS_KCLK] = s_r.keypad_clock_level;
            rdat[kpd_pkg::CS_HW_EN] = s_r.hardware_scan_enable;
            rdat[kpd_pkg::CS_KEY_DET] = s_r.key_detect_flag;
            rdat[kpd_pkg::CS_IRQ_EN] = s_r.key_detect_irq_enable;
            rd_cs = 1'b1;
          end
          kpd_pkg::IDX_CLOCK_CONTROL: begin
            rdat = {31'h0, s_r.keypad_clock_gate};
          end
          kpd_pkg::IDX_IRQ_STATUS: begin
            rdat = {30'h0, s_r.key_release_flag, s_r.key_detect_flag};
            rd_irq = 1'b1;
          end
          kpd_pkg::IDX_IRQ_MASK: begin
            rdat = {30'h0, s_r.irq_mask};
          end
          default: begin
            rdat = 32'h0;
          end
        endcase
      end
      s_nxt.hrdata = rdat;
    end

    // ahb-lite data phase write
    if (s_r.ahb_wr) begin
      case (s_r.ahb_idx)
        kpd_pkg::IDX_COLUMN_RESULT: begin
          s_nxt.column_result = hwdata_i[4:0];
        end
        kpd_pkg::IDX_SCAN_TIMING: begin
          s_nxt.scan_timing = hwdata_i[7:0];
        end
        kpd_pkg::IDX_CONTROL_STATUS: begin
          s_nxt.hardware_scan_enable = hwdata_i[kpd_pkg::CS_HW_EN];
          s_nxt.key_detect_irq_enable = hwdata_i[kpd_pkg::CS_IRQ_EN];
        end
        kpd_pkg::IDX_CLOCK_CONTROL: begin
          s_nxt.keypad_clock_gate = hwdata_i[0];
        end
        kpd_pkg::IDX_IRQ_MASK: begin
          s_nxt.irq_mask = hwdata_i[1:0];
        end
        default: begin
          // read-only index: the write is dropped
          s_nxt.scan_state = s_nxt.scan_state;
        end
      endcase
    end

    // bypass edge detect runs on the system clock, so the keypad clock is not needed
    s_nxt.rows_all_high = all_high;
    if (!s_r.hardware_scan_enable) begin
      s_nxt.scan_state = kpd_pkg::SC_IDLE;
      s_nxt.col_drive = s_nxt.column_result;
      // raw rows, no filtering: contact bounce can fire several times
      if (s_r.rows_all_high && !all_high) begin
        set_kd = 1'b1;
      end
    end else begin
      case (s_r.scan_state)
        kpd_pkg::SC_IDLE: begin
          s_nxt.col_drive = 5'h00;
          if (any_low) begin
            s_nxt.scan_state = kpd_pkg::SC_DEB_PRESS;
            s_nxt.tcnt = db_len;
          end
        end
        kpd_pkg::SC_DEB_PRESS: begin
          // confirm only after the full interval; no key held low at its end means idle again
          s_nxt.col_drive = 5'h00;
          if (ms_tick) begin
            s_nxt.tcnt = s_r.tcnt - 1'b1;
            if (s_r.tcnt <= 9'h001) begin
              if (any_low) begin
                s_nxt.scan_state = kpd_pkg::SC_SCAN;
                s_nxt.col_idx = 3'h0;
                s_nxt.hits = 2'h0;
                s_nxt.col_drive = 5'h1e;
                s_nxt.tcnt = scan_ms(s_r.scan_timing[1:0]);
              end else begin
                s_nxt.scan_state = kpd_pkg::SC_IDLE;
              end
            end
          end
        end
        kpd_pkg::SC_SCAN: begin
          // rows are read at the end of each dwell, long after the column drive settled
          if (ms_tick) begin
            s_nxt.tcnt = s_r.tcnt - 1'b1;
            if (s_r.tcnt <= 9'h001) begin
              // count keys; two or more anywhere marks the press invalid
              if (nlow != 3'h0) begin
                s_nxt.hits = (s_r.hits == 2'h0 && nlow == 3'h1) ? 2'h1 : 2'h2;
                s_nxt.hit_col = s_r.col_drive;
                s_nxt.hit_row = row_i;
              end
              if (s_r.col_idx == 3'(kpd_pkg::NUM_COLS - 1)) begin
                s_nxt.scan_state = kpd_pkg::SC_WAIT_REL;
                s_nxt.col_drive = 5'h00;
                if (s_nxt.hits == 2'h1) begin
                  s_nxt.column_result = s_nxt.hit_col;
                  s_nxt.row_result = s_nxt.hit_row;
                  set_kd = 1'b1;
                end
              end else begin
                s_nxt.col_idx = s_r.col_idx + 1'b1;
                s_nxt.col_drive = {s_r.col_drive[3:0], 1'b1};
                s_nxt.tcnt = scan_ms(s_r.scan_timing[1:0]);
              end
            end
          end
        end
        kpd_pkg::SC_WAIT_REL: begin
          // a refused multi-key press still has to be released before idle
          s_nxt.col_drive = 5'h00;
          if (all_high) begin
            s_nxt.scan_state = kpd_pkg::SC_DEB_REL;
            s_nxt.tcnt = db_len;
          end
        end
        kpd_pkg::SC_DEB_REL: begin
          s_nxt.col_drive = 5'h00;
          if (any_low) begin
            // released line bounced back; restart the release debounce
            s_nxt.tcnt = db_len;
          end else if (ms_tick) begin
            s_nxt.tcnt = s_r.tcnt - 1'b1;
            if (s_r.tcnt <= 9'h001) begin
              s_nxt.scan_state = kpd_pkg::SC_IDLE;
              set_rel = 1'b1;
            end
          end
        end
        default: s_nxt.scan_state = kpd_pkg::SC_IDLE;
      endcase
    end

    // sticky flags: a set in the same cycle as a read beats the clear
    if (rd_cs || rd_irq) begin
      s_nxt.key_detect_flag = 1'b0;
    end
    if (rd_irq) begin
      s_nxt.key_release_flag = 1'b0;
    end
    if (set_kd) begin
      s_nxt.key_detect_flag = 1'b1;
    end
    if (set_rel) begin
      s_nxt.key_release_flag = 1'b1;
    end

    // built from the next state so the pin moves on the same edge as the flag; the
    // detect enable gates only the pin, the flag still sets for polling
    irq_det = s_nxt.key_detect_flag && s_nxt.key_detect_irq_enable;
    irq_rel = s_nxt.key_release_flag;
    s_nxt.irq = (irq_det && s_nxt.irq_mask[kpd_pkg::IRQ_KEY_DET])
                || (irq_rel && s_nxt.irq_mask[kpd_pkg::IRQ_KEY_REL]);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.hreadyout <= 1'b1;
      s_r.scan_timing <= kpd_pkg::RST_SCAN_TIMING;
      s_r.irq_mask <= kpd_pkg::RST_IRQ_MASK;
      s_r.column_result <= kpd_pkg::RST_COLUMN_RESULT;
      s_r.row_result <= kpd_pkg::RST_ROW_RESULT;
      s_r.col_drive <= kpd_pkg::RST_COLUMN_RESULT;
      s_r.scan_state <= kpd_pkg::SC_IDLE;
      s_r.rows_all_high <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout_o = s_r.hreadyout;
  // only one response is ever given, so the okay code is wired
  assign hresp_o = 1'b0;
  assign hrdata_o = s_r.hrdata;
  assign col_o = s_r.col_drive;
  assign irq_o = s_r.irq;

endmodule
`default_nettype wire

// file: bench/kpd_keypad.sv
// kpd_keypad: passive switch matrix seen from the row pins
`timescale 1ns/1ps
`default_nettype none
module kpd_keypad (
  // matrix
  input wire logic [4:0] col_i,
  input wire logic [29:0] press_i,
  output logic [5:0] row_o
);
  // rows are pulled up, so an open switch never leaves a stale low level
  always_comb begin
    row_o = 6'h3f;
    for (int c = 0; c < 5; c++) begin
      for (int r = 0; r < 6; r++) begin
        if (press_i[c * 6 + r] && !col_i[c]) row_o[r] = 1'h0;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/kpd_scan_ctrl_assertions.sv
// kpd_chk: port-level checker for the keypad scanner
`timescale 1ns/1ps
`default_nettype none
module kpd_chk #(
  parameter int unsigned KCLK_HALF = 4
) (
  // bus and pins
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [31:0] hrdata_o,
  input wire logic [4:0] col_o,
  input wire logic [5:0] row_i,
  input wire logic irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic ap, wr, en, hw, kn;
  logic [7:0] ix, tm;
  logic [1:0] mk;
  logic [4:0] cl;
  wire logic req = hsel_i && htrans_i[1] && hready_i;
  wire logic [7:0] ai = haddr_i[9:2];
  wire logic rd = req && !hwrite_i && haddr_i[31:10] == 22'h0;
  wire logic mapped = ai inside {8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd8, 8'hd9, 8'hda};
  // shadow of the writable fields except the clock gate; column shadow is lost once hardware scan may overwrite it
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ap <= 1'h0;
      wr <= 1'h0;
      ix <= 8'h0;
      en <= 1'h0;
      hw <= 1'h0;
      kn <= 1'h1;
      tm <= 8'h0;
      mk <= 2'h3;
      cl <= 5'h1f;
    end else begin
      ap <= req && haddr_i[31:10] == 22'h0 && haddr_i[1:0] == 2'h0;
      wr <= hwrite_i;
      ix <= ai;
      if (ap && wr && ix == 8'hd3) tm <= hwdata_i[7:0];
      if (ap && wr && ix == 8'hd4) en <= hwdata_i[0];
      if (ap && wr && ix == 8'hd4) hw <= hwdata_i[2];
      if (ap && wr && ix == 8'hda) mk <= hwdata_i[1:0];
      if (ap && wr && ix == 8'hd1) cl <= hwdata_i[4:0];
      if (ap && wr && ix == 8'hd1) kn <= 1'h1;
      else if (hw) kn <= 1'h0;
    end
  end
  bus_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus slave not ready or not okay");
  unmapped_zero_a: assert property (rd && !mapped |=> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  timing_readback_a: assert property (rd && ai == 8'hd3 |=> hrdata_o == {24'h0, tm})
    else $error("scan timing readback wrong");
  control_readback_a: assert property (rd && ai == 8'hd4 |=>
    hrdata_o[31:4] == 28'h0 && hrdata_o[2] == hw && hrdata_o[0] == en)
    else $error("control readback wrong");
  irq_blocked_a: assert property ((!(en && mk[0]) && !mk[1]) [*3] |-> !irq_o)
    else $error("interrupt raised while disabled");
  bypass_detect_a: assert property (!hw && en && mk[0] &&
    $past(row_i) == 6'h3f && row_i != 6'h3f |-> ##[1:3] irq_o)
    else $error("row fall gave no interrupt");
  bypass_cols_a: assert property ((!hw && kn && $stable(cl)) [*2] |-> col_o == cl)
    else $error("bypass columns not from column register");
  scan_cols_a: assert property (hw [*3] |-> col_o == 5'h0 || $onehot(~col_o))
    else $error("scan column pattern illegal");
  cover property ($rose(irq_o));
  cover property (hw && $onehot(~col_o));
  cover property (rd && ai == 8'hd4);
endmodule
bind kpd_scan_ctrl kpd_chk #(.KCLK_HALF(KCLK_HALF)) i_kpd_chk (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o), .col_o(col_o),
  .row_i(row_i), .irq_o(irq_o));
`default_nettype wire

// file: bench/keypad_scan_debounce_control_tb.sv
// keypad_scan_debounce_control_tb: self-checking bench for the keypad scanner
`timescale 1ns/1ps
`default_nettype none
module keypad_scan_debounce_control_tb;
  // short keypad clock: one ms is MS cycles here
  localparam int unsigned KH = 4;
  localparam int MS = 2 * KH;
  logic ref_clk_i = 1'h0;
  logic resetn_i = 1'h0;
  logic hsel_i = 1'h0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [29:0] press = 30'h0;
  logic hready, hresp, irq;
  logic [31:0] hrdata, rd, v;
  logic [4:0] col;
  logic [5:0] row;
  logic [1:0] lv;
  int n_mismatch = 0;
  int n_compared = 0;
  int c, r;
  always #4 ref_clk_i = ~ref_clk_i;
  kpd_scan_ctrl #(.KCLK_HALF(KH)) i_kpd_scan_ctrl (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .col_o(col), .row_i(row), .irq_o(irq));
  kpd_keypad i_kpd_keypad (.col_i(col), .press_i(press), .row_o(row));
  function automatic logic [31:0] cold(input int w, input int b);
    return ((32'h1 << w) - 32'h1) & ~(32'h1 << b);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ix, input logic [31:0] wd);
    @(posedge ref_clk_i);
    hsel_i <= 1'h1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i <= {22'h0, ix, 2'h0};
    do @(posedge ref_clk_i); while (hready !== 1'h1);
    hsel_i <= 1'h0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge ref_clk_i); while (hready !== 1'h1);
    rd = hrdata;
  endtask
  task automatic wirq(input int n);
    for (int i = 0; i < n && irq !== 1'h1; i++) @(posedge ref_clk_i);
  endtask
  task automatic hw_key(input logic [5:0] db, input logic [1:0] sc, input logic two);
    int n, t, hi, dbt;
    logic [31:0] oc;
    dbt = (db == 6'h0) ? 256 : 4 * db;
    t = dbt + 5 * ((sc == 2'h0) ? 4 : sc);
    hi = (t + 3) * MS;
    c = $urandom % 5;
    r = $urandom % 6;
    bus(1'h1, 8'hd3, {24'h0, db, sc});
    bus(1'h0, 8'hd1, 32'h0);
    oc = rd;
    chk("idle cols", 32'h0, {27'h0, col});
    press <= (30'h1 << (c * 6 + r)) | (30'(two) << (((c + 1) % 5) * 6 + r));
    n = 0;
    while (irq !== 1'h1 && n < hi) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk("key latency", {31'h0, !two}, {31'h0, n >= (t - 1) * MS && n < hi});
    bus(1'h0, 8'hd4, 32'h0);
    chk("key flag", {30'h0, !two, 1'h1}, rd & 32'h3);
    bus(1'h0, 8'hd4, 32'h0);
    chk("flag clear", 32'h1, rd & 32'h3);
    bus(1'h0, 8'hd1, 32'h0);
    chk("key column", two ? oc : cold(5, c), rd);
    bus(1'h0, 8'hd2, 32'h0);
    if (!two) chk("key row", cold(6, r), rd);
    press <= 30'h0;
    // release is debounced too, so idle only after a full interval
    repeat ((dbt - 2) * MS) @(posedge ref_clk_i);
    bus(1'h0, 8'hd9, 32'h0);
    chk("release early", 32'h0, rd & 32'h3);
    repeat (hi) @(posedge ref_clk_i);
    bus(1'h0, 8'hd9, 32'h0);
    chk("release flag", 32'h2, rd & 32'h3);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(81));
    repeat (20) @(posedge ref_clk_i);
    resetn_i <= 1'h1;
    repeat (3) @(posedge ref_clk_i);
    bus(1'h0, 8'hd3, 32'h0);
    chk("timing reset", 32'h0, rd);
    bus(1'h0, 8'hd4, 32'h0);
    chk("status reset", 32'h0, rd);
    bus(1'h0, 8'hd5, 32'h0);
    chk("unmapped", 32'h0, rd);
    repeat (4) begin
      v = $urandom;
      bus(1'h1, 8'hd3, v);
      bus(1'h0, 8'hd3, 32'h0);
      chk("timing rw", v & 32'hff, rd);
      bus(1'h1, 8'hd1, v);
      repeat (2) @(posedge ref_clk_i);
      chk("col drive", v & 32'h1f, {27'h0, col});
    end
    // bypass with the keypad clock still gated off
    bus(1'h1, 8'hd1, 32'h0);
    bus(1'h1, 8'hda, 32'h1);
    c = $urandom % 30;
    press <= 30'h1 << c;
    repeat (6) @(posedge ref_clk_i);
    chk("irq disabled", 32'h0, {31'h0, irq});
    bus(1'h0, 8'hd2, 32'h0);
    chk("live rows", cold(6, c % 6), rd);
    bus(1'h0, 8'hd4, 32'h0);
    chk("flag polled", 32'h2, rd);
    bus(1'h0, 8'hd4, 32'h0);
    chk("flag cleared", 32'h0, rd);
    bus(1'h1, 8'hd4, 32'h1);
    repeat (2) begin
      press <= 30'h0;
      repeat (2) @(posedge ref_clk_i);
      press <= 30'h1 << c;
      wirq(8);
      chk("irq raised", 32'h1, {31'h0, irq});
      bus(1'h0, 8'hd4, 32'h0);
      chk("bounce flag", 32'h3, rd);
    end
    press <= 30'h0;
    bus(1'h1, 8'hd8, 32'h1);
    bus(1'h1, 8'hd4, 32'h5);
    for (int s = 0; s < 4; s++) hw_key(6'($urandom % 3 + 1), 2'(s), 1'h0);
    hw_key(6'h0, 2'h1, 1'h0);
    hw_key(6'h1, 2'h2, 1'h1);
    lv = 2'h0;
    repeat (8) begin
      bus(1'h0, 8'hd4, 32'h0);
      lv[rd[3]] = 1'h1;
    end
    chk("clock level", 32'h3, {30'h0, lv});
    tally_and_finish();
  end
endmodule
`default_nettype wire
